/* File: core/analog_trigger_detect.sv */
// analog trigger detection: source steering, threshold dacs, mode logic
//
// The address map and strobed register access were left to the implementer.
module analog_trigger_detect
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  // register port
  input  wire logic [trig_pkg::ADDR_W-1:0] addr,
  input  wire logic [trig_pkg::DATA_W-1:0] wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output      logic [trig_pkg::DATA_W-1:0] rdata,
  // comparators from the analog front end, asynchronous
  input  wire trig_pkg::cmp_t              cmp_raw,
  // threshold dacs and source steering
  output      logic [trig_pkg::DAC_W-1:0]  dac_high,
  output      logic [trig_pkg::DAC_W-1:0]  dac_low,
  output      trig_pkg::front_t            front,
  // toward the sequencers
  output      logic                        chan_hold,
  output      logic                        comparison_event,
  output      trig_pkg::action_t           action_trig,
  // routing to function and sync bus lines
  output      logic [trig_pkg::FN_N-1:0]   function_io_line_out,
  output      logic [trig_pkg::FN_N-1:0]   function_io_line_oe,
  output      logic [trig_pkg::SYNC_N-1:0] sync_bus_line_out,
  output      logic [trig_pkg::SYNC_N-1:0] sync_bus_line_oe,
  // interrupt
  output      logic                        irq
);

  trig_pkg::state_t state;
  trig_pkg::state_t next_state;
  trig_pkg::cmp_t   cmp;

  // ==========================================================================
  // saturating add or subtract on dac codes; the threshold never wraps
  // round, which would swap high and low and fire on noise
  function automatic logic [trig_pkg::DAC_W-1:0] sat_step
  (
    input logic [trig_pkg::DAC_W-1:0] a,
    input logic [trig_pkg::DAC_W-1:0] b,
    input logic                       sub
  );
    logic [trig_pkg::DAC_W:0] sum;
    sum = '0;
    if (sub)
    begin
      sum = {1'b0, a} - {1'b0, b};
      sat_step = sum[trig_pkg::DAC_W] ? '0 : sum[trig_pkg::DAC_W-1:0];
    end
    else
    begin
      sum = {1'b0, a} + {1'b0, b};
      sat_step = sum[trig_pkg::DAC_W] ? trig_pkg::DAC_MAX
                                      : sum[trig_pkg::DAC_W-1:0];
    end
  endfunction

  // ==========================================================================
  // comparator synchroniser
  trig_sync
  #(
    .W ($bits(trig_pkg::cmp_t))
  )
  u_sync
  (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (cmp_raw),
    .dout    (cmp)
  );

  // ==========================================================================
  // next state: register writes, thresholds, mode logic, read data
  always_comb
  begin
    logic band;
    logic evt;
    logic arm;
    logic [trig_pkg::INT_W-1:0] set_bits;
    logic [trig_pkg::INT_W-1:0] clr_bits;
    band     = 1'b0;
    evt      = state.event_q;
    arm      = state.armed;
    set_bits = '0;
    clr_bits = '0;
    next_state = state;
    next_state.rdata = '0;

    // register writes
    if (wr)
    begin
      unique case (addr)
        trig_pkg::REG_CTRL:
        begin
          next_state.enable = wdata[trig_pkg::CTRL_EN_BIT];
          next_state.src    = trig_pkg::src_t'(
                              wdata[trig_pkg::CTRL_SRC_LSB +: 2]);
          next_state.mode   = trig_pkg::mode_t'(
                              wdata[trig_pkg::CTRL_MODE_LSB +: 3]);
          next_state.leave  = wdata[trig_pkg::CTRL_LEAVE_BIT];
        end
        trig_pkg::REG_LEVEL:   next_state.level   = wdata[0 +: trig_pkg::DAC_W];
        trig_pkg::REG_HYST:    next_state.hyst    = wdata[0 +: trig_pkg::DAC_W];
        trig_pkg::REG_WIN_TOP: next_state.win_top = wdata[0 +: trig_pkg::DAC_W];
        trig_pkg::REG_WIN_BOT: next_state.win_bot = wdata[0 +: trig_pkg::DAC_W];
        trig_pkg::REG_INPUT:
        begin
          next_state.chan    = wdata[trig_pkg::IN_CHAN_LSB +: trig_pkg::CHAN_W];
          next_state.gnd_ref = wdata[trig_pkg::IN_GND_LSB +: 2];
          next_state.range   = wdata[trig_pkg::IN_RANGE_LSB +: 2];
        end
        trig_pkg::REG_ROUTE:
        begin
          next_state.route_fn   = wdata[trig_pkg::ROUTE_FN_LSB +:
                                        trig_pkg::FN_N];
          next_state.route_sync = wdata[trig_pkg::ROUTE_SYNC_LSB +:
                                        trig_pkg::SYNC_N];
        end
        trig_pkg::REG_ACTION:
          next_state.action = wdata[$bits(trig_pkg::action_t)-1:0];
        trig_pkg::REG_INT_STAT: clr_bits = wdata[trig_pkg::INT_W-1:0];
        trig_pkg::REG_INT_MASK:
          next_state.int_mask = wdata[trig_pkg::INT_W-1:0];
        default: ;
      endcase
    end

    // threshold dacs follow the programmed level or window limits
    unique case (state.mode)
      trig_pkg::MODE_HYST_RISE:
      begin
        next_state.dac_high = state.level;
        next_state.dac_low  = sat_step(state.level, state.hyst, 1'b1);
      end
      trig_pkg::MODE_HYST_FALL:
      begin
        next_state.dac_low  = state.level;
        next_state.dac_high = sat_step(state.level, state.hyst, 1'b0);
      end
      trig_pkg::MODE_WINDOW:
      begin
        next_state.dac_high = state.win_top;
        next_state.dac_low  = state.win_bot;
      end
      default:
      begin
        next_state.dac_high = state.level;
        next_state.dac_low  = state.level;
      end
    endcase

    // mode logic on the synchronised comparators; the comparators judge
    // the dacs already driven, so a new level takes effect after it lands
    if (!state.enable)
    begin
      evt = 1'b0;
      arm = 1'b0;
    end
    else
    begin
      unique case (state.mode)
        trig_pkg::MODE_BELOW: evt = cmp.below_low;
        trig_pkg::MODE_ABOVE: evt = cmp.above_high;
        trig_pkg::MODE_HYST_RISE:
        begin
          if (cmp.below_low)
          begin
            arm = 1'b1;
            evt = 1'b0;
          end
          else if (state.armed && cmp.above_high)
          begin
            evt = 1'b1;
            arm = 1'b0;
          end
        end
        trig_pkg::MODE_HYST_FALL:
        begin
          if (cmp.above_high)
          begin
            arm = 1'b1;
            evt = 1'b0;
          end
          else if (state.armed && cmp.below_low)
          begin
            evt = 1'b1;
            arm = 1'b0;
          end
        end
        trig_pkg::MODE_WINDOW:
        begin
          band = !cmp.above_high && !cmp.below_low;
          evt  = state.leave ? !band : band;
        end
        default:
        begin
          evt = 1'b0;
          arm = 1'b0;
        end
      endcase
    end
    next_state.event_q = evt;
    next_state.armed   = arm;

    // sticky edges of the event; a new edge beats a clear in the same cycle
    set_bits[trig_pkg::INT_RISE_BIT] = evt && !state.event_q;
    set_bits[trig_pkg::INT_FALL_BIT] = !evt && state.event_q;
    next_state.int_stat = (state.int_stat & ~clr_bits) | set_bits;

    // read data stand in the cycle after the strobe
    if (rd)
    begin
      unique case (addr)
        trig_pkg::REG_CTRL:
        begin
          next_state.rdata[trig_pkg::CTRL_EN_BIT]       = state.enable;
          next_state.rdata[trig_pkg::CTRL_SRC_LSB +: 2] = state.src;
          next_state.rdata[trig_pkg::CTRL_MODE_LSB +: 3] = state.mode;
          next_state.rdata[trig_pkg::CTRL_LEAVE_BIT]    = state.leave;
        end
        trig_pkg::REG_LEVEL:   next_state.rdata[0 +: trig_pkg::DAC_W] = state.level;
        trig_pkg::REG_HYST:    next_state.rdata[0 +: trig_pkg::DAC_W] = state.hyst;
        trig_pkg::REG_WIN_TOP: next_state.rdata[0 +: trig_pkg::DAC_W] = state.win_top;
        trig_pkg::REG_WIN_BOT: next_state.rdata[0 +: trig_pkg::DAC_W] = state.win_bot;
        trig_pkg::REG_INPUT:
        begin
          next_state.rdata[trig_pkg::IN_CHAN_LSB +: trig_pkg::CHAN_W] = state.chan;
          next_state.rdata[trig_pkg::IN_GND_LSB +: 2]   = state.gnd_ref;
          next_state.rdata[trig_pkg::IN_RANGE_LSB +: 2] = state.range;
        end
        trig_pkg::REG_ROUTE:
        begin
          next_state.rdata[trig_pkg::ROUTE_FN_LSB +: trig_pkg::FN_N] =
            state.route_fn;
          next_state.rdata[trig_pkg::ROUTE_SYNC_LSB +: trig_pkg::SYNC_N] =
            state.route_sync;
        end
        trig_pkg::REG_ACTION:
          next_state.rdata[$bits(trig_pkg::action_t)-1:0] = state.action;
        trig_pkg::REG_STATUS:
          next_state.rdata[3:0] = {cmp.below_low, cmp.above_high,
                                   state.armed, state.event_q};
        trig_pkg::REG_INT_STAT:
          next_state.rdata[trig_pkg::INT_W-1:0] = state.int_stat;
        trig_pkg::REG_INT_MASK:
          next_state.rdata[trig_pkg::INT_W-1:0] = state.int_mask;
        trig_pkg::REG_DAC:
        begin
          next_state.rdata[0 +: trig_pkg::DAC_W] = state.dac_high;
          next_state.rdata[trig_pkg::DAC_LOW_LSB +: trig_pkg::DAC_W] =
            state.dac_low;
        end
        default: ;  // unmapped reads return zero
      endcase
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state            <= '0;
      state.src        <= trig_pkg::SRC_PIN0;
      state.mode       <= trig_pkg::MODE_BELOW;
      state.level      <= trig_pkg::DAC_RESET;
      state.win_top    <= trig_pkg::DAC_RESET;
      state.win_bot    <= trig_pkg::DAC_RESET;
      state.dac_high   <= trig_pkg::DAC_RESET;
      state.dac_low    <= trig_pkg::DAC_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // outputs
  assign rdata    = state.rdata;
  assign dac_high = state.dac_high;
  assign dac_low  = state.dac_low;

  // source steering: amp only in the path for an input channel
  assign front.src     = state.src;
  assign front.amp_en  = state.src == trig_pkg::SRC_ANALOG_INPUT;
  assign front.chan    = state.chan;
  assign front.gnd_ref = state.gnd_ref;
  assign front.range   = state.range;

  // hold the input mux while a channel-sourced trigger is pending; the
  // sequencer must honour it and order its scan list to suit
  assign chan_hold = state.enable && front.amp_en
                     && !state.event_q;

  // event and its uses
  assign comparison_event = state.event_q;
  assign action_trig      = state.action
                            & {$bits(trig_pkg::action_t){state.event_q}};
  assign function_io_line_out = {trig_pkg::FN_N{state.event_q}};
  assign function_io_line_oe  = state.route_fn;
  assign sync_bus_line_out    = {trig_pkg::SYNC_N{state.event_q}};
  assign sync_bus_line_oe     = state.route_sync;

  // level interrupt while any unmasked sticky bit is set
  assign irq = |(state.int_stat & state.int_mask);

endmodule

/* File: core/trig_pkg.sv */
// package: register map, field layouts, modes and state types of the trigger
package trig_pkg;

  // ==========================================================================
  // widths
  localparam int DAC_W   = 12;
  localparam int CHAN_W  = 5;
  localparam int FN_N    = 16;
  localparam int SYNC_N  = 8;
  localparam int ADDR_W  = 4;
  localparam int DATA_W  = 32;

  // ==========================================================================
  // register indices on the plain register port
  localparam logic [ADDR_W-1:0] REG_CTRL      = 4'h0;
  localparam logic [ADDR_W-1:0] REG_LEVEL     = 4'h1;
  localparam logic [ADDR_W-1:0] REG_HYST      = 4'h2;
  localparam logic [ADDR_W-1:0] REG_WIN_TOP   = 4'h3;
  localparam logic [ADDR_W-1:0] REG_WIN_BOT   = 4'h4;
  localparam logic [ADDR_W-1:0] REG_INPUT     = 4'h5;
  localparam logic [ADDR_W-1:0] REG_ROUTE     = 4'h6;
  localparam logic [ADDR_W-1:0] REG_ACTION    = 4'h7;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 4'h8;
  localparam logic [ADDR_W-1:0] REG_INT_STAT  = 4'h9;
  localparam logic [ADDR_W-1:0] REG_INT_MASK  = 4'hA;
  localparam logic [ADDR_W-1:0] REG_DAC       = 4'hB;

  // ==========================================================================
  // control register fields
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_SRC_LSB    = 1;
  localparam int CTRL_MODE_LSB   = 4;
  localparam int CTRL_LEAVE_BIT  = 7;
  // input register fields: channel, ground reference, range
  localparam int IN_CHAN_LSB     = 0;
  localparam int IN_GND_LSB      = 8;
  localparam int IN_RANGE_LSB    = 12;
  // route register fields
  localparam int ROUTE_FN_LSB    = 0;
  localparam int ROUTE_SYNC_LSB  = 16;
  // interrupt bits
  localparam int INT_W           = 2;
  localparam int INT_RISE_BIT    = 0;
  localparam int INT_FALL_BIT    = 1;
  // dac readback field
  localparam int DAC_LOW_LSB     = 16;

  localparam logic [DAC_W-1:0] DAC_MAX   = 12'hFFF;
  localparam logic [DAC_W-1:0] DAC_RESET = 12'h800;

  // ==========================================================================
  // enumerations
  typedef enum logic [1:0] {
    SRC_PIN0,
    SRC_PIN1,
    SRC_ANALOG_INPUT
  } src_t;

  typedef enum logic [2:0] {
    MODE_BELOW,
    MODE_ABOVE,
    MODE_HYST_RISE,
    MODE_HYST_FALL,
    MODE_WINDOW
  } mode_t;

  // action enables: input acquisition, output generation, counter
  typedef struct packed {
    logic ctr;
    logic ao;
    logic ai;
  } action_t;

  // comparator pair from the analog front end
  typedef struct packed {
    logic above_high;  // source above high dac
    logic below_low;   // source below low dac
  } cmp_t;

  // front end steering toward the analog source
  typedef struct packed {
    src_t              src;
    logic              amp_en;
    logic [CHAN_W-1:0] chan;
    logic [1:0]        gnd_ref;
    logic [1:0]        range;
  } front_t;

  // all state of the trigger core
  typedef struct packed {
    logic              enable;
    src_t              src;
    mode_t             mode;
    logic              leave;
    logic [DAC_W-1:0]  level;
    logic [DAC_W-1:0]  hyst;
    logic [DAC_W-1:0]  win_top;
    logic [DAC_W-1:0]  win_bot;
    logic [CHAN_W-1:0] chan;
    logic [1:0]        gnd_ref;
    logic [1:0]        range;
    logic [FN_N-1:0]   route_fn;
    logic [SYNC_N-1:0] route_sync;
    action_t           action;
    logic [INT_W-1:0]  int_stat;
    logic [INT_W-1:0]  int_mask;
    logic              armed;
    logic              event_q;
    logic [DAC_W-1:0]  dac_high;
    logic [DAC_W-1:0]  dac_low;
    logic [DATA_W-1:0] rdata;
  } state_t;

endpackage

/* File: core/trig_sync.sv */
// two-flop synchroniser for the raw comparator outputs
module trig_sync
#(
  parameter int W = 2
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // asynchronous in, synchronised out
  input  wire logic [W-1:0] din,
  output      logic [W-1:0] dout
);

  logic [W-1:0] stage1;

  // ==========================================================================
  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1 <= '0;
      dout   <= '0;
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule

/* File: sim/analog_trigger_detect_checker.sv */
// checker: port relations of the analog trigger core
module trig_checker
(
  // clock and reset
  input wire logic              clk,
  input wire logic              reset_n,
  // register port
  input wire logic [3:0]        addr,
  input wire logic [31:0]       wdata,
  input wire logic              wr,
  // analog side and outputs
  input wire trig_pkg::cmp_t    cmp_raw,
  input wire logic [11:0]       dac_high,
  input wire logic [11:0]       dac_low,
  input wire trig_pkg::front_t  front,
  input wire logic              chan_hold,
  input wire logic              comparison_event,
  input wire trig_pkg::action_t action_trig,
  input wire logic [15:0]       function_io_line_out,
  input wire logic [7:0]        sync_bus_line_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  ctrl;
  logic [11:0] lvl;
  logic [11:0] hys;
  logic [2:0]  act;
  logic [3:0]  age;
  logic [12:0] sum;
  logic [11:0] hi_t;
  logic [11:0] lo_t;
  wire  [2:0]  mode = ctrl[6:4];
  wire         steady = ctrl[0] && age > 4'h4;
  wire         c_hi = cmp_raw.above_high;
  wire         c_lo = cmp_raw.below_low;
  wire         c_out = c_hi | c_lo;
  // ==========================================================
  // shadow registers; age counts edges since the last write so
  // that latency through the synchroniser has settled
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      ctrl <= 8'h00;
      lvl  <= 12'h800;
      hys  <= 12'h000;
      act  <= 3'h0;
      age  <= 4'h0;
    end
    else
    begin
      if (wr)
        age <= 4'h0;
      else if (age != 4'hF)
        age <= age + 4'h1;
      if (wr && addr == trig_pkg::REG_CTRL)
        ctrl <= wdata[7:0];
      if (wr && addr == trig_pkg::REG_LEVEL)
        lvl <= wdata[11:0];
      if (wr && addr == trig_pkg::REG_HYST)
        hys <= wdata[11:0];
      if (wr && addr == trig_pkg::REG_ACTION)
        act <= wdata[2:0];
    end
  // expected hysteresis thresholds, clipped at the code range
  always_comb
  begin
    sum  = {1'b0, lvl} + {1'b0, hys};
    hi_t = sum[12] ? 12'hFFF : sum[11:0];
    lo_t = (hys > lvl) ? 12'h000 : lvl - hys;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // assertions
  a_below_level:
    assert property (steady && mode == trig_pkg::MODE_BELOW |->
      comparison_event == $past(c_lo, 3)) else $error("below mode wrong");
  a_above_level:
    assert property (steady && mode == trig_pkg::MODE_ABOVE |->
      comparison_event == $past(c_hi, 3)) else $error("above mode wrong");
  a_rise_assert:
    assert property (steady && mode == trig_pkg::MODE_HYST_RISE &&
      $rose(comparison_event) |-> $past(c_hi, 3))
      else $error("rise set early");
  a_rise_release:
    assert property (steady && mode == trig_pkg::MODE_HYST_RISE &&
      $fell(comparison_event) |-> $past(c_lo, 3))
      else $error("rise cleared early");
  a_fall_assert:
    assert property (steady && mode == trig_pkg::MODE_HYST_FALL &&
      $rose(comparison_event) |-> $past(c_lo, 3))
      else $error("fall set early");
  a_window_band:
    assert property (steady && mode == trig_pkg::MODE_WINDOW |->
      comparison_event == (ctrl[7] ^ !$past(c_out, 3)))
      else $error("window mode wrong");
  a_rise_dacs:
    assert property (steady && mode == trig_pkg::MODE_HYST_RISE |->
      dac_high == lvl && dac_low == lo_t) else $error("rise dacs wrong");
  a_fall_dacs:
    assert property (steady && mode == trig_pkg::MODE_HYST_FALL |->
      dac_low == lvl && dac_high == hi_t) else $error("fall dacs wrong");
  a_line_follow:
    assert property (function_io_line_out == {16{comparison_event}} &&
      sync_bus_line_out == {8{comparison_event}})
      else $error("lines wrong");
  a_action_gate:
    assert property (action_trig == ({3{comparison_event}} & act))
      else $error("action wrong");
  a_amp_source:
    assert property (front.amp_en ==
      (front.src == trig_pkg::SRC_ANALOG_INPUT)) else $error("amp steer");
  a_hold_pending:
    assert property (chan_hold ==
      (ctrl[0] && ctrl[2:1] == 2'h2 && !comparison_event))
      else $error("channel hold wrong");
  // main scenarios reached
  c_rise: cover property (mode == trig_pkg::MODE_HYST_RISE &&
    $rose(comparison_event));
  c_window: cover property (mode == trig_pkg::MODE_WINDOW && ctrl[7] &&
    comparison_event);
  c_hold: cover property ($fell(chan_hold) && comparison_event);
endmodule

bind analog_trigger_detect trig_checker i_chk
(
  .clk(clk),
  .reset_n(reset_n),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .cmp_raw(cmp_raw),
  .dac_high(dac_high),
  .dac_low(dac_low),
  .front(front),
  .chan_hold(chan_hold),
  .comparison_event(comparison_event),
  .action_trig(action_trig),
  .function_io_line_out(function_io_line_out),
  .sync_bus_line_out(sync_bus_line_out)
);

/* File: sim/front_end_model.sv */
// front end model: source mux, scanning channel mux, comparator pair
module front_end_model
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // steering and thresholds from the trigger core
  input  wire trig_pkg::front_t front,
  input  wire logic             chan_hold,
  input  wire logic [11:0]      dac_high,
  input  wire logic [11:0]      dac_low,
  // analog levels as codes, comparator outputs
  input  wire logic [11:0]      pin0_v,
  input  wire logic [11:0]      pin1_v,
  input  wire logic [11:0]      ain_v,
  output      trig_pkg::cmp_t   cmp_raw
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0]  mux_chan;
  logic [11:0] v;
  // ==========================================================
  // scan moves every cycle unless a channel trigger is pending;
  // a pending trigger keeps a one-entry list on the trigger channel
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      mux_chan <= 5'h00;
    else if (chan_hold)
      mux_chan <= front.chan;
    else
      mux_chan <= mux_chan + 5'h01;
  // another channel, or no gain stage, shows an unrelated level
  always_comb
  begin
    case (front.src)
      trig_pkg::SRC_PIN0: v = pin0_v;
      trig_pkg::SRC_PIN1: v = pin1_v;
      default: v = (front.amp_en && mux_chan == front.chan) ? ain_v : ~ain_v;
    endcase
    cmp_raw.above_high = v > dac_high;
    cmp_raw.below_low  = v < dac_low;
  end
endmodule

/* File: sim/testbench.sv */
// testbench: register tasks, table of trigger cases, hand tests
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [11:0] lvl;
    logic [11:0] hys;
    logic [11:0] v1;
    logic [11:0] v2;
    logic [11:0] dh;
    logic [11:0] dl;
    logic        ev;
  } row_t;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic [3:0]        addr = 4'h0;
  logic [31:0]       wdata = 32'h0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [31:0]       rdata;
  logic [31:0]       got;
  logic [11:0]       pin0_v = 12'h000;
  logic [11:0]       pin1_v = 12'h000;
  logic [11:0]       ain_v = 12'h000;
  trig_pkg::cmp_t    cmp_raw;
  trig_pkg::front_t  front;
  trig_pkg::action_t action_trig;
  logic [11:0]       dac_high;
  logic [11:0]       dac_low;
  logic              chan_hold;
  logic              comparison_event;
  logic              irq;
  logic [15:0]       fn_out;
  logic [15:0]       fn_oe;
  logic [7:0]        sy_out;
  logic [7:0]        sy_oe;
  int                bad_count = 0;
  int                n_compared = 0;
  // ctrl: b0 enable, b2:1 source, b6:4 mode, b7 leave
  row_t rows [14] = '{
    '{8'h01, 12'h800, 12'h000, 12'h7FF, 12'h7FF, 12'h0, 12'h0, 1'b1},
    '{8'h03, 12'h800, 12'h000, 12'h800, 12'h800, 12'h0, 12'h0, 1'b0},
    '{8'h11, 12'h800, 12'h000, 12'h801, 12'h801, 12'h0, 12'h0, 1'b1},
    '{8'h13, 12'h800, 12'h000, 12'h800, 12'h800, 12'h0, 12'h0, 1'b0},
    '{8'h21, 12'h800, 12'h100, 12'h6FF, 12'h801, 12'h800, 12'h700, 1'b1},
    '{8'h21, 12'h800, 12'h100, 12'h700, 12'h801, 12'h800, 12'h700, 1'b0},
    '{8'h21, 12'h050, 12'h100, 12'h000, 12'hFFF, 12'h050, 12'h000, 1'b0},
    '{8'h31, 12'h800, 12'h100, 12'h901, 12'h7FF, 12'h900, 12'h800, 1'b1},
    '{8'h31, 12'h800, 12'h100, 12'h900, 12'h7FF, 12'h900, 12'h800, 1'b0},
    '{8'h33, 12'hF80, 12'h100, 12'hFFF, 12'h000, 12'hFFF, 12'hF80, 1'b0},
    '{8'h41, 12'hA00, 12'h600, 12'h800, 12'h800, 12'hA00, 12'h600, 1'b1},
    '{8'hC1, 12'hA00, 12'h600, 12'h800, 12'h800, 12'hA00, 12'h600, 1'b0},
    '{8'hC1, 12'hA00, 12'h600, 12'hB00, 12'hB00, 12'hA00, 12'h600, 1'b1},
    '{8'h41, 12'hA00, 12'h600, 12'hA00, 12'hA00, 12'hA00, 12'h600, 1'b1}};

  // 250 MHz
  always #2 clk = ~clk;

  analog_trigger_detect i_dut
  (
    .clk(clk),
    .reset_n(reset_n),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .cmp_raw(cmp_raw),
    .dac_high(dac_high),
    .dac_low(dac_low),
    .front(front),
    .chan_hold(chan_hold),
    .comparison_event(comparison_event),
    .action_trig(action_trig),
    .function_io_line_out(fn_out),
    .function_io_line_oe(fn_oe),
    .sync_bus_line_out(sy_out),
    .sync_bus_line_oe(sy_oe),
    .irq(irq)
  );

  front_end_model i_fe
  (
    .clk(clk),
    .reset_n(reset_n),
    .front(front),
    .chan_hold(chan_hold),
    .dac_high(dac_high),
    .dac_low(dac_low),
    .pin0_v(pin0_v),
    .pin1_v(pin1_v),
    .ain_v(ain_v),
    .cmp_raw(cmp_raw)
  );

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    got = rdata;
  endtask
  // unselected pin gets the inverse so a wrong source shows
  task automatic run_row(input row_t r);
    reg_wr(trig_pkg::REG_CTRL, 32'(r.ctrl & 8'hFE));
    pin0_v <= r.ctrl[1] ? ~r.v1 : r.v1;
    pin1_v <= r.ctrl[1] ? r.v1 : ~r.v1;
    reg_wr(trig_pkg::REG_LEVEL, 32'(r.lvl));
    reg_wr(trig_pkg::REG_HYST, 32'(r.hys));
    reg_wr(trig_pkg::REG_WIN_TOP, 32'(r.lvl));
    reg_wr(trig_pkg::REG_WIN_BOT, 32'(r.hys));
    reg_wr(trig_pkg::REG_CTRL, 32'(r.ctrl));
    cyc(8);
    pin0_v <= r.ctrl[1] ? ~r.v2 : r.v2;
    pin1_v <= r.ctrl[1] ? r.v2 : ~r.v2;
    cyc(8);
    check(32'(comparison_event), 32'(r.ev));
    check({sy_out, fn_out}, {{8{r.ev}}, {16{r.ev}}});
    check(32'(action_trig), 32'({3{r.ev}}));
    if (r.ctrl[6:5] != 2'h0)
      check({dac_high, dac_low}, {r.dh, r.dl});
  endtask
  task automatic final_report;
    $display("compared %0d, wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // well past the expected run; only cuts a hang
  initial
  begin
    #40000;
    bad_count++;
    final_report();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    cyc(1);
    check({dac_high, dac_low}, {12'h800, 12'h800});
    check({irq, comparison_event, fn_oe}, 18'h0);
    reg_rd(trig_pkg::REG_DAC);
    check(got, 32'h0800_0800);
    reg_rd(4'hF);
    check(got, 32'h0);
    reg_wr(trig_pkg::REG_ROUTE, 32'h00A5_5A3C);
    reg_wr(trig_pkg::REG_ACTION, 32'h7);
    reg_rd(trig_pkg::REG_ROUTE);
    check(got, 32'h00A5_5A3C);
    check({sy_oe, fn_oe}, 24'hA5_5A3C);
    foreach (rows[i])
      run_row(rows[i]);
    // interrupt: raise, mask, clear, then the falling bit
    reg_wr(trig_pkg::REG_CTRL, 32'h0);
    reg_wr(trig_pkg::REG_INT_STAT, 32'h3);
    reg_wr(trig_pkg::REG_INT_MASK, 32'h1);
    reg_wr(trig_pkg::REG_LEVEL, 32'h800);
    pin0_v <= 12'h900;
    reg_wr(trig_pkg::REG_CTRL, 32'h11);
    cyc(8);
    check(32'(irq), 32'h1);
    reg_rd(trig_pkg::REG_INT_STAT);
    check(got, 32'h1);
    reg_wr(trig_pkg::REG_INT_MASK, 32'h0);
    cyc(1);
    check(32'(irq), 32'h0);
    reg_wr(trig_pkg::REG_INT_MASK, 32'h1);
    cyc(1);
    check(32'(irq), 32'h1);
    reg_wr(trig_pkg::REG_INT_STAT, 32'h1);
    cyc(1);
    check(32'(irq), 32'h0);
    pin0_v <= 12'h700;
    cyc(8);
    check({irq, comparison_event}, 2'h0);
    reg_rd(trig_pkg::REG_INT_STAT);
    check(got, 32'h2);
    reg_wr(trig_pkg::REG_INT_MASK, 32'h3);
    cyc(1);
    check(32'(irq), 32'h1);
    // channel 3 through the amp, scan held while pending
    reg_wr(trig_pkg::REG_CTRL, 32'h0);
    reg_wr(trig_pkg::REG_INPUT, 32'h0000_2103);
    reg_wr(trig_pkg::REG_LEVEL, 32'hC00);
    ain_v <= 12'h700;
    reg_wr(trig_pkg::REG_CTRL, 32'h15);
    cyc(8);
    check(32'(front), 32'hA36);
    check({chan_hold, comparison_event}, 2'h2);
    ain_v <= 12'hD00;
    for (int k = 0; k < 20 && comparison_event !== 1'b1; k++)
      cyc(1);
    check({chan_hold, comparison_event}, 2'h1);
    final_report();
  end
endmodule
